// ---- include/eeprom_pkg.sv ----
// constants shared by the serial memory core and its pin front end
package eeprom_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int WRITE_TIME_NS = 5000000;
	// longest time: rounds down
	localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;

	// ****************************************
	// organization
	// ****************************************
	localparam int WORDS_LARGE = 256;
	localparam int WORDS_SMALL = 128;
	localparam logic [4:0] ADDR_W8 = 5'h09;
	localparam logic [4:0] ADDR_W16 = 5'h08;
	localparam logic [4:0] DATA_W8 = 5'h08;
	localparam logic [4:0] DATA_W16 = 5'h10;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// ****************************************
	// instruction codes
	// ****************************************
	localparam logic [1:0] OP_SPECIAL = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] SUB_DISABLE = 2'h0;
	localparam logic [1:0] SUB_FILL = 2'h1;
	localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
	localparam logic [1:0] SUB_ENABLE = 2'h3;

	// ****************************************
	// pin bundle positions
	// ****************************************
	localparam int PIN_N = 6;
	localparam int PIN_SEL = 0;
	localparam int PIN_SK = 1;
	localparam int PIN_DIN = 2;
	localparam int PIN_STRAP = 3;
	localparam int PIN_STRAP_CONN = 4;
	localparam int PIN_SUPPLY = 5;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_OPC = 3'h1,
		ST_ADDR = 3'h2,
		ST_DATA = 3'h3,
		ST_READ = 3'h4,
		ST_HOLD = 3'h5
	} state_e;
endpackage : eeprom_pkg

// ---- hw/pin_sync.sv ----
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise
);
	initial begin
		if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
	end

	// ****************************************
	// per-bit chain
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic s1_q, s2_q, s3_q, lvl_q, rise_q;
			logic lvl_d, rise_d;
			// a change counts once stages two and three agree
			always_comb begin
				lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
				rise_d = lvl_d & ~lvl_q;
			end
			// register the chain
			always_ff @(posedge clk_sys) begin
				if (!rstn) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					lvl_q <= 1'b0;
					rise_q <= 1'b0;
				end else begin
					s1_q <= pin[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					lvl_q <= lvl_d;
					rise_q <= rise_d;
				end
			end
			assign level[g] = lvl_q;
			assign rise[g] = rise_q;
		end
	endgenerate
endmodule : pin_sync

// ---- hw/serial_eeprom_core.sv ----
// serial memory core: instruction decode, array, self-timed programming
// What this block does
// (R1) everything ignored while select is low
// (R2) strap high: sixteen-bit words, 128/256 deep
// (R3) strap low: eight-bit words, 256/512 deep
// (R4) floating strap picks sixteen-bit words
// (R5) read decodes address, shifts word out
// (R6) write is self-timed, done within 5 ms
// (R7) write overwrites location without prior erase
// (R8) programming starts only in enabled state
// (R9) select high after write start shows status
// (R10) start bit, two-bit opcode, then address
// (R11) opcode 00 with 11 enables programming
// (R12) opcode 00 with 00 disables programming
// (R13) opcode 00 with 10 erases all, high supply
// (R14) status low while busy, high when ready
// (R15) sample on shift rise; output off unselected
`timescale 1ns/1ps
module serial_eeprom_core #(
	parameter int WORDS16 = eeprom_pkg::WORDS_LARGE,
	parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic select,
	input wire logic shift_clock,
	input wire logic serial_in,
	input wire logic word_width_strap,
	input wire logic strap_connected,
	input wire logic supply_high,
	output logic serial_out,
	output logic serial_out_oe
);
	localparam int TW = $clog2(WRITE_CYCLES + 1);
	initial begin
		if (WORDS16 != eeprom_pkg::WORDS_LARGE && WORDS16 != eeprom_pkg::WORDS_SMALL)
			$error("serial_eeprom_core: WORDS16 must be 128 or 256");
		if (WRITE_CYCLES < WORDS16)
			$error("serial_eeprom_core: WRITE_CYCLES too short for array sweep");
	end

	// ****************************************
	// pin front end
	// ****************************************
	logic [eeprom_pkg::PIN_N-1:0] pin_lvl, pin_rise;
	pin_sync #(.WIDTH(eeprom_pkg::PIN_N)) u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pin({supply_high, strap_connected, word_width_strap, serial_in, shift_clock, select}),
		.level(pin_lvl),
		.rise(pin_rise)
	);
	logic sel, sk_rise, din, wide, hi_supply;
	logic [4:0] aw, dw;
	logic [7:0] idx_mask;
	// organization from the strap, unconnected counts as high
	always_comb begin
		sel = pin_lvl[eeprom_pkg::PIN_SEL];
		sk_rise = pin_rise[eeprom_pkg::PIN_SK]; // R15
		din = pin_lvl[eeprom_pkg::PIN_DIN];
		hi_supply = pin_lvl[eeprom_pkg::PIN_SUPPLY];
		wide = pin_lvl[eeprom_pkg::PIN_STRAP_CONN] ? pin_lvl[eeprom_pkg::PIN_STRAP] : 1'b1; // R4
		aw = wide ? eeprom_pkg::ADDR_W16 : eeprom_pkg::ADDR_W8; // R2 R3
		dw = wide ? eeprom_pkg::DATA_W16 : eeprom_pkg::DATA_W8; // R2 R3
		idx_mask = 8'(WORDS16 - 1);
	end

	// ****************************************
	// array
	// ****************************************
	logic [15:0] mem [0:eeprom_pkg::WORDS_LARGE-1];
	logic mem_we;
	logic [7:0] mem_idx;
	logic [15:0] mem_wdata;
	logic [1:0] mem_lanes;
	// word index of a serial address for the current width
	function automatic logic [7:0] word_of(input logic [8:0] a, input logic w,
		input logic [7:0] m);
		word_of = (w ? a[7:0] : a[8:1]) & m; // R2 R3
	endfunction : word_of
	// byte-masked write port, written straight over old contents
	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			if (mem_lanes[0]) mem[mem_idx][7:0] <= mem_wdata[7:0]; // R7
			if (mem_lanes[1]) mem[mem_idx][15:8] <= mem_wdata[15:8]; // R7
		end
	end

	// ****************************************
	// instruction engine
	// ****************************************
	eeprom_pkg::state_e st_q, st_d;
	logic [4:0] cnt_q, cnt_d;
	logic [1:0] op_q, op_d;
	logic [8:0] addr_q, addr_d, addr_n, rd_addr;
	logic [15:0] data_q, data_d, shreg_q, shreg_d, rd_word, rd_align;
	logic en_q, en_d, status_q, status_d, dout_q, dout_d;
	logic busy_q, busy_d, all_q, all_d;
	logic [TW-1:0] timer_q, timer_d;
	logic [7:0] widx_q, widx_d;
	logic [8:0] wleft_q, wleft_d;
	logic [15:0] wdata_q, wdata_d;
	logic [1:0] wlanes_q, wlanes_d, sub;
	logic out_q, out_d, oe_q, oe_d, pend, start;

	// read port and alignment of a byte to the top of the shifter
	always_comb begin
		addr_n = {addr_q[7:0], din};
		rd_addr = (st_q == eeprom_pkg::ST_READ) ? 9'(addr_q + 9'h001) : addr_n;
		rd_word = mem[word_of(rd_addr, wide, idx_mask)];
		if (wide) rd_align = rd_word;
		else rd_align = {(rd_addr[0] ? rd_word[15:8] : rd_word[7:0]), 8'h00};
		sub = wide ? addr_q[7:6] : addr_q[8:7];
	end

	// a complete programming instruction waits for select to fall
	always_comb begin
		pend = (st_q == eeprom_pkg::ST_HOLD) && (op_q != eeprom_pkg::OP_READ);
		if (op_q == eeprom_pkg::OP_SPECIAL)
			pend = pend && (sub == eeprom_pkg::SUB_FILL || sub == eeprom_pkg::SUB_ERASE_ALL)
				&& hi_supply; // R13
		start = pend && !sel && en_q && !busy_q; // R8
	end

	// next state of the serial decoder
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		op_d = op_q;
		addr_d = addr_q;
		data_d = data_q;
		shreg_d = shreg_q;
		en_d = en_q;
		dout_d = dout_q;
		if (!sel) begin
			st_d = eeprom_pkg::ST_IDLE; // R1
		end else if (sk_rise) begin
			case (st_q)
				eeprom_pkg::ST_IDLE: begin
					// start bit, refused while programming runs
					if (din && !busy_q) begin // R10
						st_d = eeprom_pkg::ST_OPC;
						cnt_d = 5'h00;
					end
				end
				eeprom_pkg::ST_OPC: begin
					op_d = {op_q[0], din}; // R10
					cnt_d = 5'(cnt_q + 5'h01);
					if (cnt_q == 5'h01) begin
						st_d = eeprom_pkg::ST_ADDR;
						cnt_d = 5'h00;
						addr_d = 9'h000;
					end
				end
				eeprom_pkg::ST_ADDR: begin
					addr_d = addr_n;
					cnt_d = 5'(cnt_q + 5'h01);
					if (cnt_d == aw) begin
						cnt_d = 5'h00;
						st_d = eeprom_pkg::ST_HOLD;
						if (op_q == eeprom_pkg::OP_READ) begin
							st_d = eeprom_pkg::ST_READ; // R5
							shreg_d = rd_align;
							dout_d = 1'b0; // leading dummy zero
						end else if (op_q == eeprom_pkg::OP_WRITE) begin
							st_d = eeprom_pkg::ST_DATA;
						end else if (op_q == eeprom_pkg::OP_SPECIAL) begin
							case (wide ? addr_n[7:6] : addr_n[8:7])
								eeprom_pkg::SUB_ENABLE: en_d = 1'b1; // R11
								eeprom_pkg::SUB_DISABLE: en_d = 1'b0; // R12
								eeprom_pkg::SUB_FILL: st_d = eeprom_pkg::ST_DATA;
								default: st_d = eeprom_pkg::ST_HOLD; // R13
							endcase
						end
					end
				end
				eeprom_pkg::ST_DATA: begin
					data_d = {data_q[14:0], din};
					cnt_d = 5'(cnt_q + 5'h01);
					if (cnt_d == dw) st_d = eeprom_pkg::ST_HOLD;
				end
				eeprom_pkg::ST_READ: begin
					dout_d = shreg_q[15]; // R5
					shreg_d = {shreg_q[14:0], 1'b0};
					cnt_d = 5'(cnt_q + 5'h01);
					if (cnt_d == dw) begin
						// sequential read rolls into the next word
						cnt_d = 5'h00;
						addr_d = rd_addr;
						shreg_d = rd_align;
					end
				end
				default: st_d = st_q;
			endcase
		end
	end

	// next state of the self-timed programming cycle
	always_comb begin
		busy_d = busy_q;
		timer_d = timer_q;
		all_d = all_q;
		widx_d = widx_q;
		wleft_d = wleft_q;
		wdata_d = wdata_q;
		wlanes_d = wlanes_q;
		status_d = status_q;
		mem_we = busy_q && (wleft_q != 9'h000);
		mem_idx = widx_q;
		mem_wdata = wdata_q;
		mem_lanes = wlanes_q;
		if (start) begin
			busy_d = 1'b1; // R6
			timer_d = TW'(WRITE_CYCLES - 1);
			status_d = 1'b1; // R9
			all_d = (op_q == eeprom_pkg::OP_SPECIAL);
			widx_d = all_d ? 8'h00 : word_of(addr_q, wide, idx_mask);
			wleft_d = all_d ? 9'(WORDS16) : 9'h001;
			wlanes_d = (wide || all_d) ? 2'h3 : (addr_q[0] ? 2'h2 : 2'h1);
			if (op_q == eeprom_pkg::OP_ERASE || (all_d && sub == eeprom_pkg::SUB_ERASE_ALL))
				wdata_d = eeprom_pkg::ERASED_WORD;
			else if (wide) wdata_d = data_q; // R7
			else wdata_d = {data_q[7:0], data_q[7:0]};
		end else if (busy_q) begin
			if (mem_we) begin
				widx_d = 8'(widx_q + 8'h01);
				wleft_d = 9'(wleft_q - 9'h001);
			end
			if (timer_q == '0) busy_d = 1'b0; // R6
			else timer_d = TW'(timer_q - TW'(1));
		end else if (sel && sk_rise && din && st_q == eeprom_pkg::ST_IDLE) begin
			status_d = 1'b0; // new start bit ends the status display
		end
		// output pin: status, read data, or released
		oe_d = sel && (status_q || st_q == eeprom_pkg::ST_READ); // R1 R15
		out_d = status_q ? !busy_q : dout_q; // R9 R14
	end

	// register all state
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_q <= eeprom_pkg::ST_IDLE;
			cnt_q <= 5'h00;
			op_q <= 2'h0;
			addr_q <= 9'h000;
			data_q <= 16'h0000;
			shreg_q <= 16'h0000;
			en_q <= 1'b0;
			dout_q <= 1'b0;
			busy_q <= 1'b0;
			timer_q <= '0;
			all_q <= 1'b0;
			widx_q <= 8'h00;
			wleft_q <= 9'h000;
			wdata_q <= 16'h0000;
			wlanes_q <= 2'h0;
			status_q <= 1'b0;
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			op_q <= op_d;
			addr_q <= addr_d;
			data_q <= data_d;
			shreg_q <= shreg_d;
			en_q <= en_d;
			dout_q <= dout_d;
			busy_q <= busy_d;
			timer_q <= timer_d;
			all_q <= all_d;
			widx_q <= widx_d;
			wleft_q <= wleft_d;
			wdata_q <= wdata_d;
			wlanes_q <= wlanes_d;
			status_q <= status_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end
	assign serial_out = out_q;
	assign serial_out_oe = oe_q;

	// ****************************************
	// checks
	// ****************************************
	int blen_q;
	// length of the running programming cycle
	always_ff @(posedge clk_sys) begin
		if (!rstn || !busy_q) blen_q <= 0;
		else blen_q <= blen_q + 1;
	end
	sequence s_prog_start;
		$rose(busy_q);
	endsequence
	sequence s_read_entry;
		$rose(st_q == eeprom_pkg::ST_READ);
	endsequence
	a_oe_needs_select: assert property (@(posedge clk_sys) disable iff (!rstn) // R15
		serial_out_oe |-> $past(sel)) else $error("output driven while deselected");
	a_deselect_idle: assert property (@(posedge clk_sys) disable iff (!rstn) // R1
		!sel |=> st_q == eeprom_pkg::ST_IDLE) else $error("decoder active while deselected");
	a_busy_bounded: assert property (@(posedge clk_sys) disable iff (!rstn) // R6
		busy_q |-> blen_q < WRITE_CYCLES) else $error("programming cycle too long");
	a_start_enabled: assert property (@(posedge clk_sys) disable iff (!rstn) // R8
		s_prog_start |-> $past(en_q)) else $error("programming started while disabled");
	a_status_shown: assert property (@(posedge clk_sys) disable iff (!rstn) // R9
		busy_q && sel |=> serial_out_oe) else $error("status not shown");
	a_busy_low: assert property (@(posedge clk_sys) disable iff (!rstn) // R14
		status_q && busy_q ##1 serial_out_oe |-> !serial_out)
		else $error("status high while busy");
	a_read_dummy: assert property (@(posedge clk_sys) disable iff (!rstn) // R5
		s_read_entry |-> dout_q == 1'b0) else $error("read lacks leading zero");
	a_float_wide: assert property (@(posedge clk_sys) disable iff (!rstn) // R4
		!pin_lvl[eeprom_pkg::PIN_STRAP_CONN] |-> aw == eeprom_pkg::ADDR_W16 && wide)
		else $error("floating strap not sixteen-bit");
	a_disable_source: assert property (@(posedge clk_sys) disable iff (!rstn) // R12
		$fell(en_q) |-> $past(st_q == eeprom_pkg::ST_ADDR && op_q == eeprom_pkg::OP_SPECIAL))
		else $error("enable dropped without disable instruction");
endmodule : serial_eeprom_core

// ---- verif/serial_host_model.sv ----
// host model driving the three-wire serial link
`timescale 1ns/1ps
module serial_host_model (
	input wire logic clk_sys,
	output logic select,
	output logic shift_clock,
	output logic serial_in,
	input wire logic data_line
);
	// ****************************************
	// link timing, shift clock high time in clk_sys (low for twice that)
	// ****************************************
	int half = 8;
	initial begin
		select = 1'b0;
		shift_clock = 1'b0;
		serial_in = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			#1;
		end
	endtask : tick
	// one bit: stable across the rise, output sampled before next rise
	task automatic pulse(input logic b, output logic s);
		serial_in = b;
		tick(half);
		shift_clock = 1'b1;
		tick(half);
		shift_clock = 1'b0;
		tick(half);
		s = data_line;
	endtask : pulse
	// whole frame msb first, then rd clocked output bits
	task automatic xfer(input logic [31:0] bits, input int n, input int rd,
		input logic sel, output logic [15:0] q, output logic dummy);
		logic b;
		q = 16'h0;
		dummy = 1'b1;
		select = sel;
		tick(half);
		for (int i = n - 1; i >= 0; i--) begin
			pulse(bits[i], dummy);
		end
		for (int i = 0; i < rd; i++) begin
			pulse(~serial_in, b);
			q = {q[14:0], b};
		end
		select = 1'b0;
		serial_in = ~serial_in; // released line shows no stale level
		tick(half);
	endtask : xfer
	// raise select after programming and wait for ready
	task automatic status(output logic busy, output int n);
		select = 1'b1;
		tick(half);
		busy = data_line;
		n = 0;
		while (data_line !== 1'b1 && n < 1000) begin
			tick(1);
			n++;
		end
		select = 1'b0;
		tick(half);
	endtask : status
endmodule : serial_host_model

// ---- verif/serial_eeprom_core_tb_top.sv ----
// self-checking bench for the serial memory core
`timescale 1ns/1ps
module serial_eeprom_core_tb_top;
	localparam int WC = 300;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic strap = 1'b1;
	logic conn = 1'b1;
	logic supply = 1'b1;
	logic select, shift_clock, serial_in, serial_out, serial_out_oe;
	wire data_line = serial_out_oe ? serial_out : 1'bz;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	int w;
	logic [15:0] q, d;
	logic dummy, busy;
	logic [7:0] a;
	always #20 clk_sys = ~clk_sys;
	serial_eeprom_core #(.WORDS16(256), .WRITE_CYCLES(WC)) serial_eeprom_core_i (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.select(select),
		.shift_clock(shift_clock),
		.serial_in(serial_in),
		.word_width_strap(strap),
		.strap_connected(conn),
		.supply_high(supply),
		.serial_out(serial_out),
		.serial_out_oe(serial_out_oe)
	);
	serial_host_model serial_host_model_i (
		.clk_sys(clk_sys),
		.select(select),
		.shift_clock(shift_clock),
		.serial_in(serial_in),
		.data_line(data_line)
	);
	// ****************************************
	// checking and closing
	// ****************************************
	task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask : check
	task automatic wrap_up();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	// frame head: start bit, opcode, address of the current width
	function automatic logic [31:0] head(logic [1:0] op, logic [8:0] ad, logic w8);
		return w8 ? {20'h0, 1'b1, op, ad} : {21'h0, 1'b1, op, ad[7:0]};
	endfunction : head
	task automatic wr(input logic [8:0] ad, input logic [15:0] dv, input logic w8,
		input logic sel);
		logic [31:0] f, h;
		h = head(eeprom_pkg::OP_WRITE, ad, w8);
		f = w8 ? {h[23:0], dv[7:0]} : {h[15:0], dv};
		serial_host_model_i.xfer(f, w8 ? 20 : 27, 0, sel, q, dummy);
	endtask : wr
	// whole-array fill, sixteen-bit frame with data
	task automatic fill(input logic [15:0] dv);
		logic [31:0] h;
		h = head(eeprom_pkg::OP_SPECIAL, {1'b0, eeprom_pkg::SUB_FILL, 6'h0}, 1'b0);
		serial_host_model_i.xfer({h[15:0], dv}, 27, 0, 1'b1, q, dummy);
	endtask : fill
	// single-word erase, sixteen-bit frame
	task automatic er(input logic [8:0] ad);
		serial_host_model_i.xfer(head(eeprom_pkg::OP_ERASE, ad, 1'b0), 11, 0, 1'b1, q, dummy);
	endtask : er
	task automatic rd(input logic [8:0] ad, input logic w8, input logic [15:0] e);
		serial_host_model_i.xfer(head(eeprom_pkg::OP_READ, ad, w8), w8 ? 12 : 11,
			w8 ? 8 : 16, 1'b1, q, dummy);
		check("dummy", 16'h0, {15'h0, dummy});
		check("read", e, q);
		check("oe_off", 16'h0, {15'h0, serial_out_oe});
	endtask : rd
	task automatic sp(input logic [1:0] sub);
		serial_host_model_i.xfer(head(eeprom_pkg::OP_SPECIAL, {1'b0, sub, 6'h0}, 1'b0),
			11, 0, 1'b1, q, dummy);
	endtask : sp
	task automatic st();
		serial_host_model_i.status(busy, w);
		check("busy", 16'h0, {15'h0, busy});
		check("ready", 16'h1, {15'h0, w <= WC + 50});
	endtask : st
	// cut a hang short
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			wrap_up();
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h76ef));
		serial_host_model_i.tick(8);
		rstn = 1'b1;
		serial_host_model_i.tick(8);
		sp(eeprom_pkg::SUB_ENABLE);
		a = 8'($urandom);
		for (int i = 0; i < 3; i++) begin
			d = 16'($urandom);
			wr({1'b0, a}, d, 1'b0, 1'b1);
			st();
			rd({1'b0, a}, 1'b0, d);
		end
		$display("test write_overwrite done");
		wr({1'b0, a}, ~d, 1'b0, 1'b0);
		rd({1'b0, a}, 1'b0, d);
		sp(eeprom_pkg::SUB_DISABLE);
		wr({1'b0, a}, ~d, 1'b0, 1'b1);
		rd({1'b0, a}, 1'b0, d);
		$display("test ignore_and_disable done");
		sp(eeprom_pkg::SUB_ENABLE);
		supply = 1'b0;
		sp(eeprom_pkg::SUB_ERASE_ALL);
		rd({1'b0, a}, 1'b0, d);
		supply = 1'b1;
		sp(eeprom_pkg::SUB_ERASE_ALL);
		st();
		rd({1'b0, a}, 1'b0, eeprom_pkg::ERASED_WORD);
		rd({1'b0, ~a}, 1'b0, eeprom_pkg::ERASED_WORD);
		$display("test erase_all done");
		d = 16'($urandom);
		fill(d);
		st();
		rd({1'b0, a}, 1'b0, d);
		rd({1'b0, ~a}, 1'b0, d);
		er({1'b0, a});
		st();
		rd({1'b0, a}, 1'b0, eeprom_pkg::ERASED_WORD);
		rd({1'b0, ~a}, 1'b0, d);
		$display("test fill_and_erase done");
		serial_host_model_i.half = 6;
		d = 16'($urandom);
		wr({1'b0, a}, d, 1'b0, 1'b1);
		st();
		strap = 1'b0;
		rd({a, 1'b0}, 1'b1, {8'h0, d[7:0]});
		rd({a, 1'b1}, 1'b1, {8'h0, d[15:8]});
		wr({a, 1'b1}, {8'h0, ~d[15:8]}, 1'b1, 1'b1);
		st();
		strap = 1'b1;
		rd({1'b0, a}, 1'b0, {~d[15:8], d[7:0]});
		conn = 1'b0;
		strap = 1'b0;
		rd({1'b0, a}, 1'b0, {~d[15:8], d[7:0]});
		$display("test organization done");
		wrap_up();
	end
endmodule : serial_eeprom_core_tb_top
